// ===== src/qdc_dac_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Answer fixed code plus address pin bit
// - Matching address acknowledged on ninth pulse
// - Nine pulses per byte, MSB first
// - Data changes only while clock low
// - Write: address, pointer, then data bytes
// - Read: address, pointer, readdress, data out
// - Bare read uses retained pointer
// - Pointer: justification, length, channel selects
// - Justify bit: 0 left, 1 right
// - Length bit: 0 two bytes, 1 one
// - Same word to every selected channel
// - Sixteen-bit word: control then data
// - Power-down, clear, load bits lead word
// - Clear bit low zeroes all registers
// - Load bit low updates outputs of pending written channels
// - Power-on: all registers zero, normal
// - Pointer resets zero; default readback clear-bit
// - Multi-channel read: default or zero
// - Output codes are straight binary
// - Power-down mode bits select output state
// - Load copies only freshly written channels
// - Acknowledged reads repeat the same bytes
module qdc_dac_ctrl
  import qdc_pkg::*;
#(
  parameter logic [5:0] ADDR_CODE = ADDR_CODE_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic lnkClk,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addressSelectPin,
  output logic [DATA_W-1:0] dacCodeA,
  output logic [DATA_W-1:0] dacCodeB,
  output logic [DATA_W-1:0] dacCodeC,
  output logic [DATA_W-1:0] dacCodeD,
  output logic [1:0] powerdownMode
);

  // ---------------- Link domain ----------------
  logic [1:0] sclSy;
  logic [1:0] sdaSy;
  logic [1:0] aselSy;
  logic sclQ;
  logic sdaQ;
  qdc_state_t state;
  logic [3:0] bitCnt;
  logic [7:0] rxSh;
  logic [7:0] txSh;
  logic [1:0] kind;
  logic readMode;
  logic sendLo;
  logic masterAck;
  logic [7:0] pointer;
  logic [7:0] rxHi;
  logic [15:0] inWord [4];
  logic [3:0] dirty;
  logic [DATA_W-1:0] xferCode [4];
  logic [3:0] xferMask;
  logic xferZero;
  logic [1:0] xferPd;
  logic xferTgl;

  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      sclSy <= 2'h3;
      sdaSy <= 2'h3;
      aselSy <= 2'h0;
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclSy <= {sclSy[0], sclPin};
      sdaSy <= {sdaSy[0], sdaIn};
      aselSy <= {aselSy[0], addressSelectPin};
      sclQ <= sclSy[1];
      sdaQ <= sdaSy[1];
    end
  end

  // Both pins pass the same depth, so the order of data and clock edges
  // survives synchronisation; each bus phase must last several link periods
  // or its edge is never seen.
  wire sclNow = sclSy[1];
  wire sdaNow = sdaSy[1];
  wire sclRise = sclNow & ~sclQ;
  wire sclFall = ~sclNow & sclQ;
  // Edges of data while clock stays high mark frame boundaries
  wire startSeen = sclNow & sclQ & sdaQ & ~sdaNow;
  wire stopSeen = sclNow & sclQ & ~sdaQ & sdaNow;
  wire addrHit = (rxSh[7:1] == {ADDR_CODE, aselSy[1]});

  wire [3:0] chSel = pointer[3:0];
  wire singleMode = pointer[PTR_SINGLE];
  wire rightJust = pointer[PTR_RJUST];
  // Zero or several selects fall back to the default readback, or to a zero byte in one-byte mode
  wire oneSel = (chSel != 4'h0) && ((chSel & (chSel - 4'h1)) == 4'h0);
  wire byteDone = sclFall && (bitCnt == BYTE_BITS);
  wire dataKind = (kind == K_HI) || (kind == K_LO);

  // Readback word of the single selected channel
  logic [15:0] selWord;
  always_comb begin
    selWord = 16'h0000;
    for (int ch = 0; ch < 4; ch++) begin
      if (chSel[ch]) begin
        selWord = selWord | inWord[ch];
      end
    end
  end

  wire [DATA_W-1:0] selData = selWord[DATA_W-1:0];
  wire [CODE_FIELD_W-1:0] leftField = CODE_FIELD_W'(selData) << LEFT_SHIFT;
  wire [CODE_FIELD_W-1:0] rightField = CODE_FIELD_W'(selData);
  wire [15:0] jusWord = {selWord[15:12], rightJust ? rightField : leftField};
  wire [15:0] rdWord = oneSel ? jusWord : WORD_RESET;
  wire [7:0] singleByte = oneSel ? selData[DATA_W-1 -: 8] : BYTE_ZERO;
  // Readback shows the input word, not the DAC word, so a held load is visible
  wire [7:0] txHiByte = singleMode ? singleByte : rdWord[15:8];
  wire [7:0] txLoByte = rdWord[7:0];
  wire [7:0] nextTxByte = sendLo ? txLoByte : txHiByte;

  // Received word, reduced to the stored form with right-justified code
  wire [15:0] rxWord = {rxHi, rxSh};
  wire [DATA_W-1:0] rxLeftData = rxWord[CODE_FIELD_W-1 -: DATA_W];
  wire [DATA_W-1:0] rxRightData = rxWord[DATA_W-1:0];
  wire [DATA_W-1:0] rxSingleData = DATA_W'(rxSh) << SINGLE_SHIFT;
  wire [DATA_W-1:0] newData = singleMode ? rxSingleData : (rightJust ? rxRightData : rxLeftData);
  wire [3:0] newCtl = singleMode ? SINGLE_CTL : rxWord[15:12];
  wire [15:0] newWord = {newCtl, CODE_FIELD_W'(newData)};
  wire wrZero = ~newWord[W_CLR];
  wire wrLoad = ~newWord[W_OUTPUT_UPDATE_BIT];

  // Word completes only at the ack of its last byte, so a frame cut short drops it
  wire lastByte = (kind == K_LO) || ((kind == K_HI) && singleMode);
  wire commitNow = (state == ST_ACK) && sclFall && !readMode && lastByte;

  logic [15:0] next_inWord [4];
  logic [3:0] next_dirty;
  logic [3:0] loadMask;
  always_comb begin
    loadMask = 4'h0;
    for (int ch = 0; ch < 4; ch++) begin
      if (wrZero) begin
        next_inWord[ch] = WORD_RESET;
      end else if (chSel[ch]) begin
        next_inWord[ch] = newWord;
      end else begin
        next_inWord[ch] = inWord[ch];
      end
    end
    next_dirty = wrZero ? 4'h0 : (dirty | chSel);
    if (wrLoad && !wrZero) begin
      loadMask = next_dirty;
      next_dirty = 4'h0;
    end
  end

  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < 4; ch++) begin
        inWord[ch] <= WORD_RESET;
        xferCode[ch] <= '0;
      end
      dirty <= 4'h0;
      xferMask <= 4'h0;
      xferZero <= 1'b0;
      xferPd <= PD_NORMAL;
      xferTgl <= 1'b0;
    end else if (commitNow) begin
      for (int ch = 0; ch < 4; ch++) begin
        inWord[ch] <= next_inWord[ch];
        xferCode[ch] <= next_inWord[ch][DATA_W-1:0];
      end
      dirty <= next_dirty;
      xferMask <= loadMask;
      xferZero <= wrZero;
      xferPd <= newWord[W_PD_HI:W_PD_LO];
      xferTgl <= ~xferTgl;
    end
  end

  // Bytes past a word's last one start a fresh word on the same pointer
  wire [1:0] kindAfter = (kind == K_ADDR) ? K_PTR :
                         (kind == K_PTR) ? K_HI :
                         (kind == K_HI && !singleMode) ? K_LO : K_HI;

  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bitCnt <= CNT_ZERO;
      rxSh <= 8'h00;
      txSh <= 8'h00;
      kind <= K_ADDR;
      readMode <= 1'b0;
      sendLo <= 1'b0;
      masterAck <= 1'b0;
      pointer <= PTR_RESET;
      rxHi <= 8'h00;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      state <= ST_RX;
      kind <= K_ADDR;
      bitCnt <= CNT_ZERO;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        ST_RX: begin
          if (sclRise) begin
            rxSh <= {rxSh[6:0], sdaNow};
            bitCnt <= bitCnt + CNT_ONE;
          end else if (byteDone) begin
            bitCnt <= CNT_ZERO;
            if (kind == K_ADDR && !addrHit) begin
              state <= ST_IDLE;
            end else if (kind != K_ADDR && readMode) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_ACK;
              sdaOe <= 1'b1;
              if (kind == K_ADDR) begin
                readMode <= rxSh[0];
              end
              if (kind == K_PTR) begin
                pointer <= rxSh;
              end
              if (kind == K_HI) begin
                rxHi <= rxSh;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (kind == K_ADDR && readMode) begin
              state <= ST_TX;
              txSh <= txHiByte;
              sdaOe <= ~txHiByte[7];
              sendLo <= !singleMode;
            end else begin
              state <= ST_RX;
              sdaOe <= 1'b0;
              kind <= dataKind || kind == K_PTR || kind == K_ADDR ? kindAfter : K_ADDR;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt == LAST_TX_BIT) begin
              state <= ST_MACK;
              bitCnt <= CNT_ZERO;
              sdaOe <= 1'b0;
            end else begin
              bitCnt <= bitCnt + CNT_ONE;
              txSh <= {txSh[6:0], 1'b0};
              sdaOe <= ~txSh[6];
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            masterAck <= ~sdaNow;
          end else if (sclFall) begin
            if (masterAck) begin
              state <= ST_TX;
              txSh <= nextTxByte;
              sdaOe <= ~nextTxByte[7];
              sendLo <= !singleMode && !sendLo;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ---------------- Core domain ----------------
  // Transfer fields are held until the next commit, which is many bus bits away,
  // so only the toggle needs synchronising.
  logic [2:0] tglSy;
  logic [DATA_W-1:0] dacCode [4];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tglSy <= 3'h0;
    end else begin
      tglSy <= {tglSy[1:0], xferTgl};
    end
  end

  // One pulse per commit; the transfer fields change in the same link cycle as the toggle,
  // so they are stable by the time this pulse samples them.
  wire applyNow = tglSy[1] ^ tglSy[2];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < 4; ch++) begin
        dacCode[ch] <= '0;
      end
      powerdownMode <= PD_NORMAL;
    end else if (applyNow) begin
      for (int ch = 0; ch < 4; ch++) begin
        if (xferZero) begin
          dacCode[ch] <= '0;
        end else if (xferMask[ch]) begin
          dacCode[ch] <= xferCode[ch];
        end
      end
      powerdownMode <= xferPd;
    end
  end

  // Core registers drive the outputs directly
  assign dacCodeA = dacCode[0];
  assign dacCodeB = dacCode[1];
  assign dacCodeC = dacCode[2];
  assign dacCodeD = dacCode[3];

endmodule

// ===== shared/qdc_pkg.sv
package qdc_pkg;

  // Resolution of the channel codes (12-bit variant)
  localparam int DATA_W = 12;
  localparam int CODE_FIELD_W = 12;
  localparam int LEFT_SHIFT = CODE_FIELD_W - DATA_W;
  localparam int SINGLE_SHIFT = DATA_W - 8;

  // Fixed upper six address bits; value is arbitrary
  localparam logic [5:0] ADDR_CODE_DFLT = 6'h2a;

  // Transfer pointer fields
  localparam int PTR_RJUST = 5;
  localparam int PTR_SINGLE = 4;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Channel control and data word fields
  localparam int W_PD_HI = 15;
  localparam int W_PD_LO = 14;
  localparam int W_CLR = 13;
  localparam int W_OUTPUT_UPDATE_BIT = 12;
  localparam logic [15:0] WORD_RESET = 16'h2000;
  // Control nibble used by one-byte writes: normal mode, no clear, load now
  localparam logic [3:0] SINGLE_CTL = 4'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  localparam logic [1:0] K_ADDR = 2'h0;
  localparam logic [1:0] K_PTR = 2'h1;
  localparam logic [1:0] K_HI = 2'h2;
  localparam logic [1:0] K_LO = 2'h3;

  localparam logic [1:0] PD_NORMAL = 2'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } qdc_state_t;

endpackage

// ===== dv/qdc_dac_ctrl_props.sv
`timescale 1ns/1ps
module qdc_dac_ctrl_props
  import qdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic lnkClk,
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic addressSelectPin,
  input wire logic [DATA_W-1:0] dacCodeA,
  input wire logic [DATA_W-1:0] dacCodeB,
  input wire logic [DATA_W-1:0] dacCodeC,
  input wire logic [DATA_W-1:0] dacCodeD,
  input wire logic [1:0] powerdownMode
);
  logic [6:0] sinceAck;
  logic [7:0] oeLen;
  // Outputs may only move shortly after the device drove an acknowledge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sinceAck <= 7'h7f;
    else if (sdaOe) sinceAck <= 7'h00;
    else if (sinceAck != 7'h7f) sinceAck <= sinceAck + 7'h01;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) oeLen <= 8'h00;
    else oeLen <= sdaOe ? oeLen + 8'h01 : 8'h00;
  end
  sequence sclHeld;
    sclPin ##1 sclPin;
  endsequence
  a_sda_open_drain: assert property (@(posedge lnkClk) disable iff (!rst_n) sdaOut == 1'b0)
    else $error("data output not held low");
  a_data_stable_high: assert property (@(posedge lnkClk) disable iff (!rst_n) sclHeld |-> $stable(sdaOe))
    else $error("data moved while clock high");
  a_drive_clock_low: assert property (@(posedge lnkClk) disable iff (!rst_n) $rose(sdaOe) |-> !sclPin)
    else $error("data driven during clock high");
  a_reset_outputs_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (dacCodeA | dacCodeB | dacCodeC | dacCodeD) == '0 && powerdownMode == PD_NORMAL)
    else $error("outputs not zero after reset");
  a_quiet_after_reset: assert property (@(posedge lnkClk) disable iff (!rst_n) $rose(rst_n) |-> (!sdaOe) [*4])
    else $error("data driven right after reset");
  a_code_after_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed({dacCodeA, dacCodeB, dacCodeC, dacCodeD}) |-> sinceAck < 7'd24)
    else $error("code changed without a completed word");
  a_mode_after_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(powerdownMode) |-> sinceAck < 7'd24)
    else $error("mode changed without a completed word");
  a_drive_bounded: assert property (@(posedge ref_clk) disable iff (!rst_n) oeLen < 8'd140)
    else $error("data held low beyond one byte");
endmodule
bind qdc_dac_ctrl qdc_dac_ctrl_props u_qdc_dac_ctrl_props (.ref_clk, .rst_n, .lnkClk, .sclPin, .sdaIn, .sdaOut,
  .sdaOe, .addressSelectPin, .dacCodeA, .dacCodeB, .dacCodeC, .dacCodeD, .powerdownMode);

// ===== dv/qdc_bus_master.sv
`timescale 1ns/1ps
module qdc_bus_master (
  input wire logic ref_clk,
  input wire logic sdaOe,
  output logic sclPin,
  output logic sdaMst
);
  initial begin
    sclPin = 1'b1;
    sdaMst = 1'b1;
  end
  // Third of a bit of four core cycles keeps each clock phase far above the sampler's minimum
  task automatic hp;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic bitIo(input logic v, output logic r);
    hp;
    sdaMst <= v;
    hp;
    sclPin <= 1'b1;
    hp;
    r = sdaMst & ~sdaOe;
    sclPin <= 1'b0;
  endtask
  task automatic start;
    hp;
    sdaMst <= 1'b1;
    hp;
    sclPin <= 1'b1;
    hp;
    sdaMst <= 1'b0;
    hp;
    sclPin <= 1'b0;
  endtask
  task automatic stop;
    hp;
    sdaMst <= 1'b0;
    hp;
    sclPin <= 1'b1;
    hp;
    sdaMst <= 1'b1;
    hp;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(b[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask
  task automatic rdByte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
    bitIo(~ack, r);
  endtask
endmodule

// ===== dv/tb_qdc_dac_ctrl.sv
`timescale 1ns/1ps
module tb_qdc_dac_ctrl
  import qdc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic lnkClk = 1'b0;
  logic rst_n = 1'b0;
  logic addressSelectPin = 1'b1;
  logic sclPin, sdaMst, sdaOut, sdaOe;
  logic [DATA_W-1:0] dacCodeA, dacCodeB, dacCodeC, dacCodeD;
  logic [1:0] powerdownMode;
  int num_errors = 0;
  int tests_run = 0;
  wire sdaBus = sdaMst & ~sdaOe;
  localparam logic [6:0] DEV = {ADDR_CODE_DFLT, 1'b1};
  always #25 ref_clk = ~ref_clk;
  always #6 lnkClk = ~lnkClk;
  qdc_dac_ctrl u_qdc_dac_ctrl (.ref_clk, .rst_n, .lnkClk, .sclPin, .sdaIn(sdaBus), .sdaOut, .sdaOe,
    .addressSelectPin, .dacCodeA, .dacCodeB, .dacCodeC, .dacCodeD, .powerdownMode);
  qdc_bus_master u_qdc_bus_master (.ref_clk, .sdaOe, .sclPin, .sdaMst);
  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkCodes(input logic [49:0] exp);
    repeat (8) @(posedge ref_clk);
    chk({powerdownMode, dacCodeA, dacCodeB, dacCodeC, dacCodeD}, exp);
  endtask
  task automatic addr(input logic [7:0] b, input logic exp);
    logic a;
    u_qdc_bus_master.start;
    u_qdc_bus_master.wrByte(b, a);
    chk(50'(a), 50'(exp));
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w, input int nb);
    logic a;
    addr({DEV, 1'b0}, 1'b1);
    u_qdc_bus_master.wrByte(ptr, a);
    if (nb > 0) u_qdc_bus_master.wrByte(w[15:8], a);
    if (nb > 1) u_qdc_bus_master.wrByte(w[7:0], a);
    u_qdc_bus_master.stop;
  endtask
  // Four bytes with acks on all but the last exercise the repeat of the readback word
  task automatic rd(input logic direct, input logic [7:0] ptr, input logic [15:0] e, input int nb);
    logic a;
    logic [7:0] b;
    if (!direct) begin
      addr({DEV, 1'b0}, 1'b1);
      u_qdc_bus_master.wrByte(ptr, a);
    end
    addr({DEV, 1'b1}, 1'b1);
    for (int k = 0; k < 4; k++) begin
      u_qdc_bus_master.rdByte(k < 3, b);
      chk(50'(b), 50'((nb == 2 && k[0]) ? e[7:0] : e[15:8]));
    end
    u_qdc_bus_master.stop;
  endtask
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chkCodes(50'h0);
    rd(1'b1, 8'h00, 16'h2000, 2);
    endTest("reset");
    addr({ADDR_CODE_DFLT, 1'b0, 1'b0}, 1'b0);
    u_qdc_bus_master.stop;
    endTest("address");
    addressSelectPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    addr({ADDR_CODE_DFLT, 1'b0, 1'b0}, 1'b1);
    u_qdc_bus_master.stop;
    addr({DEV, 1'b0}, 1'b0);
    u_qdc_bus_master.stop;
    addressSelectPin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    endTest("address_pin");
    wr(8'h23, 16'h3abc, 2);
    chkCodes(50'h0);
    rd(1'b0, 8'h02, 16'h3abc, 2);
    endTest("load_hold");
    wr(8'h04, 16'h6123, 2);
    chkCodes({2'h1, 12'habc, 12'habc, 12'h123, 12'h000});
    endTest("load_all");
    rd(1'b0, 8'h03, 16'h2000, 2);
    rd(1'b0, 8'h13, 16'h0000, 1);
    endTest("multi_read");
    wr(8'h18, 16'h9f00, 1);
    chkCodes({2'h0, 12'habc, 12'habc, 12'h123, 12'h9f0});
    rd(1'b0, 8'h18, 16'h9f00, 1);
    endTest("single");
    wr(8'h01, 16'h6555, 1);
    chkCodes({2'h0, 12'habc, 12'habc, 12'h123, 12'h9f0});
    endTest("partial");
    wr(8'h22, 16'hf456, 2);
    chkCodes({2'h3, 12'habc, 12'habc, 12'h123, 12'h9f0});
    rd(1'b0, 8'h22, 16'hf456, 2);
    endTest("powerdown");
    wr(8'h01, 16'h0000, 2);
    chkCodes(50'h0);
    rd(1'b1, 8'h00, 16'h2000, 2);
    endTest("clear");
    complete_run;
  end
endmodule
